/* File: core/fipd_pkg.sv */
// Shared constants and types for the fast input position decoder.
// Assumes a 200 MHz hclk and a word-aligned AHB-Lite register window.
package fipd_pkg;

  // ----------------------------------------
  // Modes and selections
  // ----------------------------------------
  // Decoding mode of the two fast inputs
  typedef enum logic [1:0] {
    MODE_STEP_DIR   = 2'b00,
    MODE_DUAL_PULSE = 2'b01,
    MODE_QUAD       = 2'b10,
    MODE_OFF        = 2'b11
  } fipd_mode_e;

  // Variable routed onto an auxiliary analog output
  typedef enum logic [1:0] {
    SEL_SPEED    = 2'b00,
    SEL_CURRENT  = 2'b01,
    SEL_POSITION = 2'b10,
    SEL_USER     = 2'b11
  } fipd_sel_e;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_POS = 8'h04;
  localparam logic [7:0] OFS_AUX_SEL = 8'h08;
  localparam logic [7:0] OFS_AUX_SCALE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_USER = 8'h14;
  localparam logic [7:0] OFS_REG_POS = 8'h18;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_HALL_BIT = 2;
  localparam int CTRL_OT_BIT = 3;
  localparam int SEL0_LSB = 0;
  localparam int SEL1_LSB = 4;
  localparam int SCALE0_LSB = 0;
  localparam int SCALE1_LSB = 16;
  localparam int ST_REG_BIT = 0;
  localparam int ST_OT_BIT = 1;
  localparam int ST_A_BIT = 2;
  localparam int ST_B_BIT = 3;
  localparam int ST_THIRD_BIT = 4;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam fipd_mode_e RST_MODE = MODE_STEP_DIR;
  localparam fipd_sel_e RST_SEL0 = SEL_SPEED;
  localparam fipd_sel_e RST_SEL1 = SEL_CURRENT;
  localparam logic [15:0] SCALE_UNITY = 16'h0100;
  localparam int SCALE_FRAC = 8;
  localparam int AUX_W = 16;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int REFRESH_US = 400;
  localparam int REFRESH_CYC = REFRESH_US * CLK_MHZ;

endpackage : fipd_pkg

/* File: core/fipd_edge.sv */
// Edge detector for one fast input.
// Assumes the input is already synchronous to hclk.
module fipd_edge (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sig,
  output logic rise,
  output logic fall
);

  logic prev;

  // ----------------------------------------
  // Previous level
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev <= 1'b0;
    end else begin
      prev <= sig;
    end
  end

  // Edges relative to last cycle
  assign rise = sig & ~prev;
  assign fall = ~sig & prev;

endmodule : fipd_edge

/* File: core/fipd_aux_chan.sv */
// One auxiliary analog output channel: select, scale, hold.
// Assumes refresh is a one-cycle tick from the refresh timer.
module fipd_aux_chan
  import fipd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic refresh,
  input wire fipd_sel_e sel,
  input wire logic [15:0] scale,
  input wire logic [AUX_W-1:0] speed,
  input wire logic [AUX_W-1:0] current,
  input wire logic [AUX_W-1:0] position,
  input wire logic [AUX_W-1:0] user,
  output logic [AUX_W-1:0] value
);

  logic [AUX_W-1:0] pick;
  logic signed [AUX_W+16:0] prod;

  // ----------------------------------------
  // Source select and fixed-point scale
  // ----------------------------------------
  always_comb begin
    case (sel)
      SEL_SPEED: pick = speed;
      SEL_CURRENT: pick = current;
      SEL_POSITION: pick = position;
      SEL_USER: pick = user;
      default: pick = speed;
    endcase
  end

  // No saturation: large scales wrap, software keeps them in range
  assign prod = $signed(pick) * $signed({1'b0, scale});

  // Output only moves on the refresh tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value <= '0;
    end else if (refresh) begin
      value <= prod[SCALE_FRAC +: AUX_W];
    end
  end

endmodule : fipd_aux_chan

/* File: core/fipd_top.sv */
// Fast input position decoder with AHB-Lite register access.
// Assumes fast inputs are synchronous to hclk; single-word bus only.
// What this block does
// - Quadrature: A rising, B low counts CCW
// - Refresh both aux outputs every 400 us
// - Aux outputs default speed, current; scalable
// - Hall motor type claims third input
// - Otherwise third input registers position
// - Over-temperature checked only when enabled
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
module fipd_top
  import fipd_pkg::*;
#(
  parameter int REFRESH_CYCLES = REFRESH_CYC,
  parameter int POS_W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic fast_input_phase_a,
  input wire logic fast_input_phase_b,
  input wire logic fast_input_third,
  input wire logic motor_overtemp_in,
  input wire logic [AUX_W-1:0] speed_in,
  input wire logic [AUX_W-1:0] current_in,
  output logic step_pulse,
  output logic step_cw,
  output logic [AUX_W-1:0] aux_out0,
  output logic [AUX_W-1:0] aux_out1,
  output logic aux_update,
  output logic hall_commutation_sensor,
  output logic registration_event,
  output logic overtemp_fault
);

  localparam int CNT_W = $clog2(REFRESH_CYCLES + 1);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (REFRESH_CYCLES < 2) begin : g_bad_refresh
    $error("REFRESH_CYCLES must be at least 2");
  end
  if (POS_W < AUX_W || POS_W > 32) begin : g_bad_pos
    $error("POS_W must lie between 16 and 32");
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  fipd_mode_e mode;
  fipd_sel_e aux_sel0;
  fipd_sel_e aux_sel1;
  logic hall_type;
  logic ot_check_en;
  logic [15:0] scale0;
  logic [15:0] scale1;
  logic [AUX_W-1:0] user_val;
  logic signed [POS_W-1:0] pos;
  logic signed [POS_W-1:0] reg_pos;
  logic reg_flag;

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  logic take;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] rd_word;
  logic wr_pos;
  logic wr_status;

  // Valid transfer in the address phase
  assign take = hsel & hready & htrans[1];

  // Write address held over to the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= take & hwrite;
      if (take) begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  assign wr_pos = wr_pend && wr_addr == OFS_POS;
  assign wr_status = wr_pend && wr_addr == OFS_STATUS;

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_word = '0;
    case (haddr[7:0])
      OFS_CTRL: begin
        rd_word[CTRL_MODE_LSB +: 2] = mode;
        rd_word[CTRL_HALL_BIT] = hall_type;
        rd_word[CTRL_OT_BIT] = ot_check_en;
      end
      OFS_POS: rd_word[POS_W-1:0] = pos;
      OFS_AUX_SEL: begin
        rd_word[SEL0_LSB +: 2] = aux_sel0;
        rd_word[SEL1_LSB +: 2] = aux_sel1;
      end
      OFS_AUX_SCALE: begin
        rd_word[SCALE0_LSB +: 16] = scale0;
        rd_word[SCALE1_LSB +: 16] = scale1;
      end
      OFS_STATUS: begin
        rd_word[ST_REG_BIT] = reg_flag;
        rd_word[ST_OT_BIT] = overtemp_fault;
        rd_word[ST_A_BIT] = fast_input_phase_a;
        rd_word[ST_B_BIT] = fast_input_phase_b;
        rd_word[ST_THIRD_BIT] = fast_input_third;
      end
      OFS_USER: rd_word[AUX_W-1:0] = user_val;
      OFS_REG_POS: rd_word[POS_W-1:0] = reg_pos;
      default: rd_word = '0;
    endcase
  end

  // Read data captured in the address phase, shown in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (take && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= RST_MODE;
      hall_type <= 1'b0;
      ot_check_en <= 1'b0;
      aux_sel0 <= RST_SEL0;
      aux_sel1 <= RST_SEL1;
      scale0 <= SCALE_UNITY;
      scale1 <= SCALE_UNITY;
      user_val <= '0;
    end else if (wr_pend) begin
      case (wr_addr)
        OFS_CTRL: begin
          mode <= fipd_mode_e'(hwdata[CTRL_MODE_LSB +: 2]);
          hall_type <= hwdata[CTRL_HALL_BIT];
          ot_check_en <= hwdata[CTRL_OT_BIT];
        end
        OFS_AUX_SEL: begin
          aux_sel0 <= fipd_sel_e'(hwdata[SEL0_LSB +: 2]);
          aux_sel1 <= fipd_sel_e'(hwdata[SEL1_LSB +: 2]);
        end
        OFS_AUX_SCALE: begin
          scale0 <= hwdata[SCALE0_LSB +: 16];
          scale1 <= hwdata[SCALE1_LSB +: 16];
        end
        OFS_USER: user_val <= hwdata[AUX_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Step decoding
  // ----------------------------------------
  logic a_rise;
  logic b_rise;
  logic b_fall;
  logic t_rise;
  logic next_step;
  logic next_cw;

  fipd_edge u_edge_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .sig(fast_input_phase_a),
    .rise(a_rise),
    .fall()
  );

  fipd_edge u_edge_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .sig(fast_input_phase_b),
    .rise(b_rise),
    .fall(b_fall)
  );

  fipd_edge u_edge_t (
    .hclk(hclk),
    .hresetn(hresetn),
    .sig(fast_input_third),
    .rise(t_rise),
    .fall()
  );

  // One step per cycle at most; both dual-pulse edges at once cancel
  always_comb begin
    next_step = 1'b0;
    next_cw = 1'b0;
    case (mode)
      MODE_QUAD: begin
        next_step = a_rise;
        next_cw = fast_input_phase_b;
      end
      MODE_STEP_DIR: begin
        next_step = b_fall;
        next_cw = fast_input_phase_a;
      end
      MODE_DUAL_PULSE: begin
        if (a_rise && !fast_input_phase_b) begin
          next_step = 1'b1;
        end else if (b_rise && !fast_input_phase_a) begin
          next_step = 1'b1;
          next_cw = 1'b1;
        end
      end
      default: next_step = 1'b0;
    endcase
  end

  // Step outputs and position count; a step wins over a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_pulse <= 1'b0;
      step_cw <= 1'b0;
      pos <= '0;
    end else begin
      step_pulse <= next_step;
      if (next_step) begin
        step_cw <= next_cw;
        pos <= next_cw ? pos + POS_W'(1) : pos - POS_W'(1);
      end else if (wr_pos) begin
        pos <= hwdata[POS_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Third input and over-temperature
  // ----------------------------------------
  // Hall motors own the third input; otherwise it latches position
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hall_commutation_sensor <= 1'b0;
      registration_event <= 1'b0;
      reg_pos <= '0;
    end else begin
      hall_commutation_sensor <= hall_type & fast_input_third;
      registration_event <= !hall_type && t_rise;
      if (!hall_type && t_rise) begin
        reg_pos <= pos;
      end
    end
  end

  // Sticky capture flag, write one to clear; a new capture wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg_flag <= 1'b0;
    end else if (!hall_type && t_rise) begin
      reg_flag <= 1'b1;
    end else if (wr_status && hwdata[ST_REG_BIT]) begin
      reg_flag <= 1'b0;
    end
  end

  // Sensor ignored while the check is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overtemp_fault <= 1'b0;
    end else begin
      overtemp_fault <= ot_check_en & motor_overtemp_in;
    end
  end

  // ----------------------------------------
  // Auxiliary output refresh
  // ----------------------------------------
  logic [CNT_W-1:0] ref_cnt;
  logic tick;

  // Free-running period, independent of the selected variables
  assign tick = ref_cnt == CNT_W'(REFRESH_CYCLES - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt <= '0;
      aux_update <= 1'b0;
    end else begin
      ref_cnt <= tick ? '0 : ref_cnt + CNT_W'(1);
      aux_update <= tick;
    end
  end

  fipd_aux_chan u_aux0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .refresh(tick),
    .sel(aux_sel0),
    .scale(scale0),
    .speed(speed_in),
    .current(current_in),
    .position(pos[AUX_W-1:0]),
    .user(user_val),
    .value(aux_out0)
  );

  fipd_aux_chan u_aux1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .refresh(tick),
    .sel(aux_sel1),
    .scale(scale1),
    .speed(speed_in),
    .current(current_in),
    .position(pos[AUX_W-1:0]),
    .user(user_val),
    .value(aux_out1)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [CNT_W-1:0] gap;
  logic seen;

  // Cycles since the last refresh, for the period check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap <= '0;
      seen <= 1'b0;
    end else begin
      gap <= aux_update ? '0 : gap + CNT_W'(1);
      seen <= seen | aux_update;
    end
  end

  property p_quad_ccw;
    @(posedge hclk) disable iff (!hresetn)
    mode == MODE_QUAD && a_rise && !fast_input_phase_b |=> step_pulse && !step_cw;
  endproperty
  a_quad_ccw: assert property (p_quad_ccw) else $error("quad CCW step missed");

  property p_quad_cw;
    @(posedge hclk) disable iff (!hresetn)
    mode == MODE_QUAD && a_rise && fast_input_phase_b |=> step_pulse && step_cw;
  endproperty
  a_quad_cw: assert property (p_quad_cw) else $error("quad CW step missed");

  property p_step_dir;
    @(posedge hclk) disable iff (!hresetn)
    mode == MODE_STEP_DIR && b_fall |=> step_pulse && step_cw == $past(fast_input_phase_a);
  endproperty
  a_step_dir: assert property (p_step_dir) else $error("step/dir step wrong");

  property p_dual_block;
    @(posedge hclk) disable iff (!hresetn)
    mode == MODE_DUAL_PULSE && fast_input_phase_a && fast_input_phase_b |=> !step_pulse;
  endproperty
  a_dual_block: assert property (p_dual_block) else $error("blocked pulse counted");

  property p_refresh;
    @(posedge hclk) disable iff (!hresetn)
    aux_update && seen |-> gap == CNT_W'(REFRESH_CYCLES - 1);
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh period wrong");

  property p_aux_speed;
    @(posedge hclk) disable iff (!hresetn)
    tick && aux_sel0 == SEL_SPEED && scale0 == SCALE_UNITY |=> aux_out0 == $past(speed_in);
  endproperty
  a_aux_speed: assert property (p_aux_speed) else $error("aux0 not speed");

  property p_hall;
    @(posedge hclk) disable iff (!hresetn)
    hall_type |=> !registration_event && hall_commutation_sensor == $past(fast_input_third);
  endproperty
  a_hall: assert property (p_hall) else $error("hall input misused");

  property p_regist;
    @(posedge hclk) disable iff (!hresetn)
    !hall_type && t_rise |=> registration_event && reg_pos == $past(pos);
  endproperty
  a_regist: assert property (p_regist) else $error("registration missed");

  property p_ot;
    @(posedge hclk) disable iff (!hresetn)
    !ot_check_en |=> !overtemp_fault;
  endproperty
  a_ot: assert property (p_ot) else $error("overtemp not gated");

endmodule : fipd_top

/* File: test/fipd_src.sv */
// Behavioural pulse source and motor sensor on the far side of the decoder.
// Assumes callers run its task from one process; levels move after hclk rises.
module fipd_src (
  input wire logic hclk,
  output logic phase_a,
  output logic phase_b,
  output logic third,
  output logic overtemp
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet levels from time zero
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    third = 1'b0;
    overtemp = 1'b0;
  end

  // New levels just after an edge, held for hold more cycles; hold 0 is fastest
  task automatic move(input logic a, input logic b, input logic t, input logic o,
                      input int hold);
    @(posedge hclk);
    phase_a <= a;
    phase_b <= b;
    third <= t;
    overtemp <= o;
    repeat (hold) @(posedge hclk);
  endtask : move
endmodule : fipd_src

/* File: test/fast_input_position_decoder_tb.sv */
// Self-checking bench for the fast input position decoder.
// Assumes zero-wait AHB-Lite slave and a short refresh period of 16 cycles.
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module fast_input_position_decoder_tb;
  import fipd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RC = 16;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] ab0;
    logic [1:0] ab1;
    logic [1:0] d;
  } fipd_row_s;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, exp_pos, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic a, b, third, ot, step_pulse, step_cw, aux_update, hall_sen, reg_ev, ot_fault;
  logic [15:0] speed_in, current_in, aux_out0, aux_out1;
  int bad_count, cmp_count, pulses, regs, p0, n;
  // Mode, A/B before, A/B after, step (+1 = 01, -1 = 11)
  fipd_row_s rows [10] = '{
    '{2'h0, 2'h3, 2'h2, 2'h1}, '{2'h0, 2'h1, 2'h0, 2'h3}, '{2'h0, 2'h2, 2'h3, 2'h0},
    '{2'h1, 2'h0, 2'h2, 2'h3}, '{2'h1, 2'h0, 2'h1, 2'h1}, '{2'h1, 2'h1, 2'h3, 2'h0},
    '{2'h2, 2'h0, 2'h2, 2'h3}, '{2'h2, 2'h1, 2'h3, 2'h1}, '{2'h2, 2'h3, 2'h1, 2'h0},
    '{2'h3, 2'h0, 2'h2, 2'h0}};

  // ----------------------------------------
  // Design, source and clock
  // ----------------------------------------
  fipd_top #(.REFRESH_CYCLES(RC)) u_fipd_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .fast_input_phase_a(a), .fast_input_phase_b(b), .fast_input_third(third),
    .motor_overtemp_in(ot), .speed_in(speed_in), .current_in(current_in),
    .step_pulse(step_pulse), .step_cw(step_cw), .aux_out0(aux_out0), .aux_out1(aux_out1),
    .aux_update(aux_update), .hall_commutation_sensor(hall_sen),
    .registration_event(reg_ev), .overtemp_fault(ot_fault));
  fipd_src u_fipd_src (.hclk(hclk), .phase_a(a), .phase_b(b), .third(third), .overtemp(ot));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // Pulse tallies, so no one-cycle pulse slips past a check
  always @(posedge hclk) begin
    if (step_pulse === 1'b1) pulses++;
    if (reg_ev === 1'b1) regs++;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("bad_count=%0d cmp_count=%0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // Bounded wait for hready; a slave that never answers ends the run
  task automatic rdy();
    int k;
    k = 0;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin bad_count++; tally_and_finish(); end
  endtask : rdy

  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, ad};
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask : bus

  task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h00000000);
    `CHK(rd, e)
  endtask : rchk

  // Sampled on the falling edge, where registered outputs have settled
  task automatic wait_aux();
    n = 0;
    do begin @(negedge hclk); n++; end while (aux_update !== 1'b1 && n < 100);
    if (aux_update !== 1'b1) begin bad_count++; tally_and_finish(); end
  endtask : wait_aux

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    speed_in = 16'h1357;
    current_in = 16'hFEDC;
    exp_pos = 32'h00000000;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(OFS_CTRL, 32'h00000000);
    rchk(OFS_AUX_SEL, 32'h00000010);
    rchk(OFS_AUX_SCALE, 32'h01000100);
    rchk(8'h1C, 32'h00000000);
    `CHK(hresp, 1'b0)
    // Each mode from its row's starting A/B levels; setup happens with decoding off
    foreach (rows[i]) begin
      bus(1'b1, OFS_CTRL, 32'h00000003);
      u_fipd_src.move(rows[i].ab0[1], rows[i].ab0[0], 1'b0, 1'b0, 3);
      bus(1'b1, OFS_CTRL, {30'h00000000, rows[i].mode});
      p0 = pulses;
      u_fipd_src.move(rows[i].ab1[1], rows[i].ab1[0], 1'b0, 1'b0, 4);
      exp_pos = exp_pos + {{30{rows[i].d[1]}}, rows[i].d};
      `CHK(pulses - p0, int'(rows[i].d != 2'h0))
      if (rows[i].d != 2'h0) `CHK(step_cw, ~rows[i].d[1])
      rchk(OFS_POS, exp_pos);
    end
    // Back-to-back falls at the fastest rate, wrapping through zero
    bus(1'b1, OFS_CTRL, 32'h00000003);
    u_fipd_src.move(1'b1, 1'b1, 1'b0, 1'b0, 2);
    bus(1'b1, OFS_CTRL, 32'h00000000);
    bus(1'b1, OFS_POS, 32'hFFFFFFFF);
    p0 = pulses;
    for (int k = 0; k < 5; k++) begin
      u_fipd_src.move(1'b1, 1'b0, 1'b0, 1'b0, 0);
      u_fipd_src.move(1'b1, 1'b1, 1'b0, 1'b0, 0);
    end
    u_fipd_src.move(1'b1, 1'b1, 1'b0, 1'b0, 4);
    exp_pos = 32'h00000004;
    `CHK(pulses - p0, 5)
    rchk(OFS_POS, exp_pos);
    // Aux defaults, refresh period, then reassigned and scaled
    wait_aux();
    `CHK(aux_out0, speed_in)
    `CHK(aux_out1, current_in)
    wait_aux();
    `CHK(n, RC)
    bus(1'b1, OFS_AUX_SEL, 32'h00000023);
    bus(1'b1, OFS_USER, 32'h00001234);
    bus(1'b1, OFS_AUX_SCALE, 32'h02000200);
    wait_aux();
    `CHK(aux_out0, 16'h2468)
    `CHK(aux_out1, {exp_pos[14:0], 1'b0})
    // Third input: hall sensor, then registration
    bus(1'b1, OFS_CTRL, 32'h00000007);
    p0 = regs;
    u_fipd_src.move(1'b1, 1'b1, 1'b1, 1'b0, 4);
    `CHK(hall_sen, 1'b1)
    `CHK(regs - p0, 0)
    u_fipd_src.move(1'b0, 1'b0, 1'b0, 1'b0, 2);
    bus(1'b1, OFS_CTRL, 32'h00000003);
    u_fipd_src.move(1'b0, 1'b0, 1'b1, 1'b0, 4);
    `CHK(regs - p0, 1)
    `CHK(hall_sen, 1'b0)
    rchk(OFS_REG_POS, exp_pos);
    rchk(OFS_STATUS, 32'h00000011);
    bus(1'b1, OFS_STATUS, 32'h00000001);
    rchk(OFS_STATUS, 32'h00000010);
    // Over-temperature ignored until its check is enabled
    u_fipd_src.move(1'b0, 1'b0, 1'b0, 1'b1, 3);
    `CHK(ot_fault, 1'b0)
    bus(1'b1, OFS_CTRL, 32'h0000000B);
    rchk(OFS_STATUS, 32'h00000002);
    `CHK(ot_fault, 1'b1)
    // Second reset in mid-run clears state
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    `CHK(ot_fault, 1'b0)
    `CHK(aux_out0, 16'h0000)
    hresetn <= 1'b1;
    rchk(OFS_POS, 32'h00000000);
    rchk(OFS_CTRL, 32'h00000000);
    tally_and_finish();
  end
endmodule : fast_input_position_decoder_tb
